// ---- logic/art_pkg.sv ----
// constants shared by the auto-reload timer and its clock source
package art_pkg;

    // ****************************************
    // register offsets on the plain port
    // ****************************************
    localparam logic [3:0] ART_OFF_CTRL = 4'h0;
    localparam logic [3:0] ART_OFF_CNT_LO = 4'h1;
    localparam logic [3:0] ART_OFF_CNT_HI = 4'h2;
    localparam logic [3:0] ART_OFF_RLD_LO = 4'h3;
    localparam logic [3:0] ART_OFF_RLD_HI = 4'h4;
    localparam logic [3:0] ART_OFF_CLKCTL = 4'h5;
    localparam logic [3:0] ART_OFF_IEN = 4'h6;

    // ****************************************
    // timer_control_reg fields
    // ****************************************
    localparam int ART_CTL_HFLAG = 7;
    localparam int ART_CTL_LFLAG = 6;
    localparam int ART_CTL_LIEN = 5;
    localparam int ART_CTL_CAPEN = 4;
    localparam int ART_CTL_SPLIT = 3;
    localparam int ART_CTL_RUN = 2;
    localparam int ART_CTL_XCLK = 0;
    localparam logic [7:0] ART_CTL_RST = 8'h00;
    localparam logic [7:0] ART_CTL_RSVD_MASK = 8'hFD;

    // ****************************************
    // clock_control_reg and interrupt enable fields
    // ****************************************
    localparam int ART_CKC_LOSEL = 4;
    localparam int ART_CKC_HISEL = 5;
    localparam int ART_IEN_TIMER = 5;
    localparam logic [7:0] ART_BYTE_RST = 8'h00;

    // ****************************************
    // clock dividers
    // ****************************************
    localparam int ART_SYS_DIV = 12;
    localparam int ART_EXT_DIV = 8;
    localparam logic [3:0] ART_DIV12_LAST = 4'(ART_SYS_DIV - 1);
    localparam logic [2:0] ART_EXT_RISE_AT = 3'(ART_EXT_DIV / 2 - 1);
    localparam logic [2:0] ART_EXT_FALL_AT = 3'(ART_EXT_DIV - 1);
    localparam logic [7:0] ART_BYTE_MAX = 8'hFF;

endpackage

// ---- logic/art_clk_src.sv ----
// divide-by-12 tick and synchronised external oscillator divided by 8
`timescale 1ns/1ps

module art_clk_src
    import art_pkg::*;
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // external oscillator pin
    input wire logic extOsc,
    // one-cycle enables
    output logic tickDiv12,
    output logic tickExt,
    output logic fallExt
);

    logic oscMeta_q, oscSync_q, oscPrev_q;
    logic [3:0] div12Cnt_q, div12Cnt_d;
    logic [2:0] extCnt_q, extCnt_d;
    logic tickDiv12_d, tickExt_d, fallExt_d;
    logic oscRise;

    // divider next values; the meta stage feeds only the sync stage
    always_comb
    begin
        oscRise = oscSync_q & ~oscPrev_q;
        div12Cnt_d = (div12Cnt_q == ART_DIV12_LAST) ? 4'h0 : div12Cnt_q + 4'h1;
        tickDiv12_d = (div12Cnt_q == ART_DIV12_LAST);
        extCnt_d = oscRise ? extCnt_q + 3'h1 : extCnt_q;
        tickExt_d = oscRise && (extCnt_q == ART_EXT_RISE_AT);  // divided clock rises
        fallExt_d = oscRise && (extCnt_q == ART_EXT_FALL_AT);  // divided clock falls
    end

    // registers
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            oscMeta_q <= 1'b0;
            oscSync_q <= 1'b0;
            oscPrev_q <= 1'b0;
            div12Cnt_q <= 4'h0;
            extCnt_q <= 3'h0;
            tickDiv12 <= 1'b0;
            tickExt <= 1'b0;
            fallExt <= 1'b0;
        end
        else
        begin
            oscMeta_q <= extOsc;
            oscSync_q <= oscMeta_q;
            oscPrev_q <= oscSync_q;
            div12Cnt_q <= div12Cnt_d;
            extCnt_q <= extCnt_d;
            tickDiv12 <= tickDiv12_d;
            tickExt <= tickExt_d;
            fallExt <= fallExt_d;
        end
    end

endmodule

// ---- logic/art_timer.sv ----
// 16-bit / dual 8-bit auto-reload timer with external oscillator capture
`timescale 1ns/1ps

// Function
// - count built from two byte registers
// - split bit selects 16-bit or two 8-bit
// - clock: system_clock, system_clock/12, synced ext/8
// - 16-bit wrap loads reload, sets high flag
// - timer enable interrupts on 16-bit overflow
// - low enable adds low byte rollover interrupt
// - split: each byte reloads its own value
// - split: run gates high byte only
// - split: per-byte select, shared ext select
// - split: each byte wrap sets its flag
// - split interrupts: high, or either with enable
// - flags cleared only by software
// - capture clock: low byte system_clock or system_clock/12
// - capture copies count into reload, sets flag
// - capture on falling edge of ext/8
// - capture enable bit turns capture on
// - low flag set on every low rollover
module art_timer
    import art_pkg::*;
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // register port
    input wire logic [3:0] regAddr,
    input wire logic [7:0] regWdata,
    input wire logic regWe,
    input wire logic regRe,
    output logic [7:0] regRdata,
    // external oscillator pin
    input wire logic extOsc,
    // interrupt request to the core
    output logic timerIrq
);

    // ****************************************
    // state
    // ****************************************
    logic [7:0] ctrl_q, ctrl_d;
    logic [7:0] countLowByte_q, countLowByte_d;
    logic [7:0] countHighByte_q, countHighByte_d;
    logic [7:0] reloadLowByte_q, reloadLowByte_d;
    logic [7:0] reloadHighByte_q, reloadHighByte_d;
    logic [7:0] clkCtl_q, clkCtl_d;
    logic [7:0] intEn_q, intEn_d;
    logic [7:0] regRdata_d;
    logic timerIrq_d;

    logic tickDiv12, tickExt, fallExt;
    logic wrCtl, wrCntLo, wrCntHi, wrRldLo, wrRldHi;
    logic splitModeSelect, runControl, externalClockSelect, captureModeEnable;
    logic lowByteIrqEnable, highOverflowFlag, lowOverflowFlag;
    logic lowByteClockSelect, highByteClockSelect, timerIntEnable;
    logic tickLow, tickHigh, lowWrap, highWrap, setHigh, setLow, capEvent;

    // ****************************************
    // clock sources
    // ****************************************
    art_clk_src u_clk_src (
        .clk_sys(clk_sys),
        .rst(rst),
        .extOsc(extOsc),
        .tickDiv12(tickDiv12),
        .tickExt(tickExt),
        .fallExt(fallExt)
    );

    // ****************************************
    // decode
    // ****************************************
    // field views and write strobes
    always_comb
    begin
        splitModeSelect = ctrl_q[ART_CTL_SPLIT];
        runControl = ctrl_q[ART_CTL_RUN];
        externalClockSelect = ctrl_q[ART_CTL_XCLK];
        captureModeEnable = ctrl_q[ART_CTL_CAPEN];
        lowByteIrqEnable = ctrl_q[ART_CTL_LIEN];
        highOverflowFlag = ctrl_q[ART_CTL_HFLAG];
        lowOverflowFlag = ctrl_q[ART_CTL_LFLAG];
        lowByteClockSelect = clkCtl_q[ART_CKC_LOSEL];
        highByteClockSelect = clkCtl_q[ART_CKC_HISEL];
        timerIntEnable = intEn_q[ART_IEN_TIMER];
        wrCtl = regWe && (regAddr == ART_OFF_CTRL);
        wrCntLo = regWe && (regAddr == ART_OFF_CNT_LO);
        wrCntHi = regWe && (regAddr == ART_OFF_CNT_HI);
        wrRldLo = regWe && (regAddr == ART_OFF_RLD_LO);
        wrRldHi = regWe && (regAddr == ART_OFF_RLD_HI);
    end

    // ****************************************
    // clock selection
    // ****************************************
    // per-byte select; capture mode keeps the low byte off the external tick
    always_comb
    begin
        if (lowByteClockSelect)
            tickLow = 1'b1;
        else if (externalClockSelect && !captureModeEnable)
            tickLow = tickExt;
        else
            tickLow = tickDiv12;
        if (highByteClockSelect)
            tickHigh = 1'b1;
        else if (externalClockSelect)
            tickHigh = tickExt;
        else
            tickHigh = tickDiv12;
        capEvent = captureModeEnable && fallExt;
    end

    // ****************************************
    // counter bytes
    // ****************************************
    // count, wrap and reload; a software write to a byte wins
    always_comb
    begin
        countLowByte_d = countLowByte_q;
        countHighByte_d = countHighByte_q;
        setHigh = 1'b0;
        setLow = 1'b0;
        lowWrap = (countLowByte_q == ART_BYTE_MAX);
        highWrap = (countHighByte_q == ART_BYTE_MAX);
        if (!splitModeSelect)
        begin
            if (runControl && tickLow)
            begin
                setLow = lowWrap;
                if (lowWrap && highWrap)
                begin
                    countLowByte_d = reloadLowByte_q;
                    countHighByte_d = reloadHighByte_q;
                    setHigh = 1'b1;
                end
                else
                begin
                    {countHighByte_d, countLowByte_d} =
                        {countHighByte_q, countLowByte_q} + 16'h0001;
                end
            end
        end
        else
        begin
            if (tickLow)
            begin
                setLow = lowWrap;
                countLowByte_d = lowWrap ? reloadLowByte_q : countLowByte_q + 8'h01;
            end
            if (runControl && tickHigh)
            begin
                setHigh = highWrap;
                countHighByte_d = highWrap ? reloadHighByte_q : countHighByte_q + 8'h01;
            end
        end
        if (wrCntLo)
            countLowByte_d = regWdata;
        if (wrCntHi)
            countHighByte_d = regWdata;
    end

    // ****************************************
    // reload, control and configuration
    // ****************************************
    // capture overrides a write to the reload pair; flag set beats clear
    always_comb
    begin
        reloadLowByte_d = wrRldLo ? regWdata : reloadLowByte_q;
        reloadHighByte_d = wrRldHi ? regWdata : reloadHighByte_q;
        if (capEvent)
        begin
            reloadLowByte_d = countLowByte_q;
            reloadHighByte_d = countHighByte_q;
        end
        ctrl_d = wrCtl ? (regWdata & ART_CTL_RSVD_MASK) : ctrl_q;
        ctrl_d[ART_CTL_HFLAG] = ctrl_d[ART_CTL_HFLAG] | setHigh | capEvent;
        ctrl_d[ART_CTL_LFLAG] = ctrl_d[ART_CTL_LFLAG] | setLow;
        clkCtl_d = (regWe && regAddr == ART_OFF_CLKCTL) ? regWdata : clkCtl_q;
        intEn_d = (regWe && regAddr == ART_OFF_IEN) ? regWdata : intEn_q;
    end

    // ****************************************
    // interrupt request and read data
    // ****************************************
    // request follows the flags; read data only in the cycle after a read
    always_comb
    begin
        timerIrq_d = timerIntEnable &&
            (highOverflowFlag || (lowByteIrqEnable && lowOverflowFlag));
        regRdata_d = 8'h00;
        if (regRe)
        begin
            case (regAddr)
                ART_OFF_CTRL: regRdata_d = ctrl_q;
                ART_OFF_CNT_LO: regRdata_d = countLowByte_q;
                ART_OFF_CNT_HI: regRdata_d = countHighByte_q;
                ART_OFF_RLD_LO: regRdata_d = reloadLowByte_q;
                ART_OFF_RLD_HI: regRdata_d = reloadHighByte_q;
                ART_OFF_CLKCTL: regRdata_d = clkCtl_q;
                ART_OFF_IEN: regRdata_d = intEn_q;
                default: regRdata_d = 8'h00;
            endcase
        end
    end

    // ****************************************
    // registers
    // ****************************************
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            ctrl_q <= ART_CTL_RST;
            countLowByte_q <= ART_BYTE_RST;
            countHighByte_q <= ART_BYTE_RST;
            reloadLowByte_q <= ART_BYTE_RST;
            reloadHighByte_q <= ART_BYTE_RST;
            clkCtl_q <= ART_BYTE_RST;
            intEn_q <= ART_BYTE_RST;
            regRdata <= 8'h00;
            timerIrq <= 1'b0;
        end
        else
        begin
            ctrl_q <= ctrl_d;
            countLowByte_q <= countLowByte_d;
            countHighByte_q <= countHighByte_d;
            reloadLowByte_q <= reloadLowByte_d;
            reloadHighByte_q <= reloadHighByte_d;
            clkCtl_q <= clkCtl_d;
            intEn_q <= intEn_d;
            regRdata <= regRdata_d;
            timerIrq <= timerIrq_d;
        end
    end

    // ****************************************
    // assertions
    // ****************************************
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);

    logic noCntWrite;
    assign noCntWrite = !wrCntLo && !wrCntHi && !wrCtl && !capEvent;

    sequence s_wrap16;
        !splitModeSelect && runControl && tickLow && noCntWrite &&
            countLowByte_q == ART_BYTE_MAX && countHighByte_q == ART_BYTE_MAX;
    endsequence

    sequence s_capture;
        capEvent && !wrCtl;
    endsequence

    sequence s_div12_gap;
        !tickDiv12 [*8] ##1 !tickDiv12 ##1 !tickDiv12 ##1 !tickDiv12 ##1 tickDiv12;
    endsequence

    a_wrap16_reload: assert property (s_wrap16 |=> countLowByte_q == $past(reloadLowByte_q)
        && countHighByte_q == $past(reloadHighByte_q) && highOverflowFlag && lowOverflowFlag)
        else $error("16-bit wrap did not reload");

    a_irq_high_flag: assert property ((timerIntEnable && highOverflowFlag) |=> timerIrq)
        else $error("high flag did not request interrupt");

    a_irq_low_gate: assert property ((timerIntEnable && lowOverflowFlag && !highOverflowFlag)
        |=> timerIrq == $past(lowByteIrqEnable))
        else $error("low flag interrupt gating wrong");

    a_split_low_free: assert property ((splitModeSelect && !runControl && tickLow && !wrCntLo
        && countLowByte_q != ART_BYTE_MAX) |=> countLowByte_q == $past(countLowByte_q) + 8'h01)
        else $error("split low byte not counting");

    a_split_high_wrap: assert property ((splitModeSelect && runControl && tickHigh && !wrCntHi
        && !wrCtl && countHighByte_q == ART_BYTE_MAX)
        |=> countHighByte_q == $past(reloadHighByte_q) && highOverflowFlag)
        else $error("split high byte wrap wrong");

    a_hold_stopped: assert property ((!splitModeSelect && !runControl && !wrCntLo && !wrCntHi)
        |=> $stable({countHighByte_q, countLowByte_q}))
        else $error("stopped 16-bit counter moved");

    a_capture_copy: assert property (s_capture |=> reloadLowByte_q == $past(countLowByte_q)
        && reloadHighByte_q == $past(countHighByte_q) && highOverflowFlag)
        else $error("capture did not copy count");

    a_flag_sticky: assert property ((highOverflowFlag && !wrCtl) |=> highOverflowFlag [*2]
        or (highOverflowFlag ##1 wrCtl))
        else $error("high flag cleared by hardware");

    a_low_flag_any: assert property ((setLow && !wrCtl) ##1 !wrCtl |-> ##1 lowOverflowFlag)
        else $error("low rollover did not set flag");

    a_div12_rate: assert property (tickDiv12 |=> s_div12_gap)
        else $error("divide by 12 tick spacing wrong");

    a_read_slot: assert property ((!regRe) |=> regRdata == 8'h00)
        else $error("read data outside read slot");

endmodule

// ---- verif/tb.sv ----
// self-checking bench for the auto-reload timer with capture
`timescale 1ns/1ps

module tb;
    import art_pkg::*;

    // ****************************************
    // design ports and bench state
    // ****************************************
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic [3:0] regAddr = 4'h0;
    logic [7:0] regWdata = 8'h00;
    logic regWe = 1'b0;
    logic regRe = 1'b0;
    logic [7:0] regRdata;
    logic extOsc = 1'b0;
    logic timerIrq;
    logic reSeen = 1'b0;
    logic [7:0] lastRd = 8'h00;
    logic [15:0] expQ[$]; // {mask, expected}
    int n_fail = 0;
    int n_compared = 0;
    integer seed = 32'h81EC21CD;

    art_timer art_timer_inst (
        .clk_sys(clk_sys),
        .rst(rst),
        .regAddr(regAddr),
        .regWdata(regWdata),
        .regWe(regWe),
        .regRe(regRe),
        .regRdata(regRdata),
        .extOsc(extOsc),
        .timerIrq(timerIrq)
    );

    // ****************************************
    // clocks: 100 MHz system, free oscillator of unrelated phase
    // ****************************************
    always #5 clk_sys = ~clk_sys;
    always #14.7 extOsc = ~extOsc;

    // ****************************************
    // compare, verdict and bus tasks
    // ****************************************
    task automatic check(input logic [7:0] seen, input logic [7:0] want);
        n_compared++;
        if (seen !== want)
        begin
            n_fail++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, want);
        end
    endtask

    task automatic end_of_test;
        if (n_fail == 0 && n_compared > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // strobes are left standing; the next task or cyc decides them
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        regWe <= 1'b1;
        regRe <= 1'b0;
        regAddr <= a;
        regWdata <= d;
        @(posedge clk_sys);
    endtask

    task automatic rd(input logic [3:0] a, input logic [7:0] want, input logic [7:0] mask);
        regWe <= 1'b0;
        regRe <= 1'b1;
        regAddr <= a;
        expQ.push_back({mask, want});
        @(posedge clk_sys);
    endtask

    task automatic cyc(input int n);
        regWe <= 1'b0;
        regRe <= 1'b0;
        repeat (n) @(posedge clk_sys);
    endtask

    // read whose value is kept for arithmetic instead of compared
    task automatic rdv(input logic [3:0] a, output logic [7:0] v);
        rd(a, 8'h00, 8'h00);
        cyc(1);
        #1;
        v = lastRd;
    endtask

    // bounded wait for the interrupt line; two edges first so a stale request drains
    task automatic wait_irq(input int n);
        regWe <= 1'b0;
        regRe <= 1'b0;
        repeat (2) @(posedge clk_sys);
        for (int i = 0; i < n && timerIrq !== 1'b1; i++)
            @(posedge clk_sys);
    endtask

    // ****************************************
    // read-data monitor: oldest note against the answer
    // ****************************************
    always @(posedge clk_sys)
    begin
        logic [15:0] e;
        if (reSeen && expQ.size() > 0)
        begin
            e = expQ.pop_front();
            lastRd = regRdata;
            if (e[15:8] != 8'h00)
                check(regRdata & e[15:8], e[7:0]);
        end
        reSeen <= regRe;
    end

    // ****************************************
    // watchdog
    // ****************************************
    initial
    begin
        #200000;
        n_fail++;
        end_of_test();
    end

    // ****************************************
    // main sequence
    // ****************************************
    initial
    begin
        logic [7:0] r;
        logic [7:0] a;
        logic [7:0] b;
        repeat (20) @(posedge clk_sys);
        rst <= 1'b0;
        cyc(1);
        // reset values, unmapped offsets and plain storage
        for (int i = 0; i < 16; i++)
            rd(4'(i), 8'h00, 8'hFF);
        wr(4'h9, 8'hFF);
        rd(4'h9, 8'h00, 8'hFF);
        wr(ART_OFF_CTRL, 8'h02);
        rd(ART_OFF_CTRL, 8'h00, 8'hFF);
        r = 8'($random(seed));
        wr(ART_OFF_CLKCTL, r);
        rd(ART_OFF_CLKCTL, r, 8'hFF);
        r = 8'($random(seed));
        wr(ART_OFF_CNT_LO, r);
        cyc(20);
        rd(ART_OFF_CNT_LO, r, 8'hFF);
        // 16-bit wrap with random reload
        r = {1'b0, 7'($random(seed))};
        wr(ART_OFF_RLD_LO, 8'h00);
        wr(ART_OFF_RLD_HI, r);
        rd(ART_OFF_RLD_HI, r, 8'hFF);
        wr(ART_OFF_CLKCTL, 8'h10);
        wr(ART_OFF_IEN, 8'h20);
        wr(ART_OFF_CNT_LO, 8'hFD);
        wr(ART_OFF_CNT_HI, 8'hFF);
        wr(ART_OFF_CTRL, 8'h04);
        wait_irq(20);
        check({7'h00, timerIrq}, 8'h01);
        rd(ART_OFF_CNT_HI, r, 8'hFF);
        rd(ART_OFF_RLD_HI, r, 8'hFF);
        cyc(10);
        rd(ART_OFF_CTRL, 8'hC4, 8'hFF);
        wr(ART_OFF_CTRL, 8'h04);
        cyc(3);
        check({7'h00, timerIrq}, 8'h00);
        // low rollover in 16-bit mode, then its interrupt enable
        cyc(300);
        check({7'h00, timerIrq}, 8'h00);
        rd(ART_OFF_CTRL, 8'h44, 8'hFF);
        wr(ART_OFF_CTRL, 8'h64);
        cyc(3);
        check({7'h00, timerIrq}, 8'h01);
        // split mode: low free running, high gated by run
        b = 8'($random(seed));
        wr(ART_OFF_CTRL, 8'h00);
        wr(ART_OFF_CNT_LO, 8'hFE);
        wr(ART_OFF_CNT_HI, 8'hFE);
        wr(ART_OFF_RLD_LO, 8'hA0);
        wr(ART_OFF_RLD_HI, b);
        wr(ART_OFF_CTRL, 8'h08);
        cyc(20);
        rd(ART_OFF_CNT_HI, 8'hFE, 8'hFF);
        rd(ART_OFF_CTRL, 8'h48, 8'hFF);
        rd(ART_OFF_CNT_LO, 8'hA0, 8'hE0);
        check({7'h00, timerIrq}, 8'h00);
        wr(ART_OFF_CTRL, 8'h0C);
        wait_irq(40);
        check({7'h00, timerIrq}, 8'h01);
        rd(ART_OFF_CNT_HI, b, 8'hFF);
        rd(ART_OFF_CTRL, 8'h8C, 8'hBF);
        wr(ART_OFF_CTRL, 8'h28);
        wait_irq(120);
        check({7'h00, timerIrq}, 8'h01);
        rd(ART_OFF_CTRL, 8'h68, 8'hFF);
        // clock sources: system_clock/12, then external divided by 8
        wr(ART_OFF_CLKCTL, 8'h00);
        for (int k = 0; k < 2; k++)
        begin
            wr(ART_OFF_CTRL, 8'h00);
            wr(ART_OFF_CNT_LO, 8'h00);
            wr(ART_OFF_CNT_HI, 8'h00);
            wr(ART_OFF_CTRL, (k == 0) ? 8'h04 : 8'h05);
            cyc((k == 0) ? 120 : 235);
            rd(ART_OFF_CNT_LO, 8'h08, 8'hF8);
        end
        // capture of the external oscillator
        wr(ART_OFF_CTRL, 8'h00);
        wr(ART_OFF_CNT_LO, 8'h00);
        wr(ART_OFF_CNT_HI, 8'h00);
        wr(ART_OFF_RLD_LO, 8'h00);
        wr(ART_OFF_RLD_HI, 8'h00);
        wr(ART_OFF_CLKCTL, 8'h10);
        wr(ART_OFF_CTRL, 8'h14);
        wait_irq(40);
        check({7'h00, timerIrq}, 8'h01);
        rd(ART_OFF_CTRL, 8'h94, 8'hFF);
        rd(ART_OFF_RLD_HI, 8'h00, 8'hFF);
        rdv(ART_OFF_RLD_LO, a);
        wr(ART_OFF_CTRL, 8'h14);
        cyc(3);
        wait_irq(40);
        rdv(ART_OFF_RLD_LO, b);
        r = b - a;
        check({7'h00, (r >= 8'h16 && r <= 8'h1A)}, 8'h01);
        cyc(2);
        end_of_test();
    end

endmodule
